// file: logic/mfrf_cfg.svh
// Register offsets, field positions, reset values and fixed codes of the mesh relay filter.
`ifndef MFRF_CFG_SVH
`define MFRF_CFG_SVH
`define MFRF_OFF_CTRL     8'h00
`define MFRF_OFF_NODE     8'h04
`define MFRF_OFF_HOPS     8'h08
`define MFRF_OFF_BNEXT    8'h0C
`define MFRF_OFF_TBL      8'h10
`define MFRF_OFF_STAT0    8'h14
`define MFRF_OFF_STAT1    8'h18
`define MFRF_CTRL_RELAY   0
`define MFRF_CTRL_UNI     1
`define MFRF_CTRL_BCAST   2
`define MFRF_TBL_IDX_LSB  16
`define MFRF_TBL_MEMBER   24
`define MFRF_TBL_BPREV    25
`define MFRF_HOPS_W       4
`define MFRF_HOPS_RST     4'h7
`define MFRF_BNEXT_RST    16'hFFFF
`define MFRF_ALL_NODES    16'hFFFF
`define MFRF_ADM_SHORT    2'h3
`define MFRF_ADM_NONE     2'h0
`define MFRF_RESP_OKAY    2'h0
`define MFRF_RESP_SLVERR  2'h2
`endif

// file: logic/mfrf_pkg.sv
// Shared types of the mesh relay filter.
`include "mfrf_cfg.svh"
package mfrf_pkg;
  typedef enum logic [3:0] {
    MFRF_DEC_DROP = 4'h1,
    MFRF_DEC_FWD  = 4'h2,
    MFRF_DEC_DLV  = 4'h4,
    MFRF_DEC_BOTH = 4'h8
  } mfrf_dec_t;

  typedef struct packed {
    logic [15:0]              dest;
    logic [15:0]              origin;
    logic [15:0]              final_addr;
    logic [`MFRF_HOPS_W-1:0]  hops;
    logic [1:0]               addressing_mode_field;
    logic [7:0]               tag;
  } mfrf_txrec_t;
endpackage

// file: logic/mfrf_relay.sv
// Mesh relay filter: frame header decisions, relaying tables, two-entry send buffer, AXI4-Lite.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`include "mfrf_cfg.svh"
// Notes on behaviour
// [R01] Unicast relay only when assigned, mesh header present, not final, all addresses known.
// [R02] A relayed frame carries the received hop count minus one.
// [R03] A frame arriving with hop count zero is never relayed.
// [R04] Unicast next hop comes from the source route or the relaying table.
// [R05] Unknown final address means the unicast frame is dropped.
// [R06] Frames for this node are delivered only when the previous hop is known; frames without a mesh header are delivered with no previous hop check.
// [R07] Originated relayed frames mark both short-address mode flags.
// [R08] Originated frames start with the configured maximum hop count.
// [R09] Broadcast origination uses own identifier as origin and all-nodes as final.
// [R10] Broadcast origination sends to the configured next node or to all nodes.
// [R11] A single-hop destination of all-nodes is accepted like our own identifier.
// [R12] Broadcast relays deliver new frames once and relay them when checks pass.
// [R13] Any failed broadcast acceptance check stops forwarding.
// [R14] Broadcast relays forward to the configured next node or all nodes.
// [R15] Unknown previous hop or unknown origin drops a broadcast frame.
// [R16] Non-relay nodes deliver checked broadcast frames at most once.
// [R17] Unassigned nodes discard frames not meant for them.
// [R18] With relaying disabled, nothing is originated for relaying or kept for others.
// [R19] Tables are loaded by software and consulted before each decision.
module mfrf_relay
  import mfrf_pkg::*;
#(
  parameter int IDX_W = 6
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     ce_i,
  input  wire logic [7:0]               s_axi_awaddr_i,
  input  wire logic                     s_axi_awvalid_i,
  output logic                          s_axi_awready_o,
  input  wire logic [31:0]              s_axi_wdata_i,
  input  wire logic [3:0]               s_axi_wstrb_i,
  input  wire logic                     s_axi_wvalid_i,
  output logic                          s_axi_wready_o,
  output logic [1:0]                    s_axi_bresp_o,
  output logic                          s_axi_bvalid_o,
  input  wire logic                     s_axi_bready_i,
  input  wire logic [7:0]               s_axi_araddr_i,
  input  wire logic                     s_axi_arvalid_i,
  output logic                          s_axi_arready_o,
  output logic [31:0]                   s_axi_rdata_o,
  output logic [1:0]                    s_axi_rresp_o,
  output logic                          s_axi_rvalid_o,
  input  wire logic                     s_axi_rready_i,
  input  wire logic                     rx_valid_i,
  output logic                          rx_ready_o,
  input  wire logic                     rx_mesh_hdr_i,
  input  wire logic [15:0]              rx_source_short_id_i,
  input  wire logic [15:0]              rx_dest_short_id_i,
  input  wire logic [15:0]              rx_mesh_origin_addr_i,
  input  wire logic [15:0]              rx_mesh_final_addr_i,
  input  wire logic [`MFRF_HOPS_W-1:0]  rx_hops_left_field_i,
  input  wire logic                     rx_sr_valid_i,
  input  wire logic [15:0]              rx_sr_next_i,
  input  wire logic [7:0]               rx_tag_i,
  input  wire logic                     org_valid_i,
  output logic                          org_ready_o,
  input  wire logic [15:0]              org_mesh_final_addr_i,
  input  wire logic [7:0]               org_tag_i,
  output logic                          tx_valid_o,
  input  wire logic                     tx_ready_i,
  output logic [15:0]                   tx_dest_short_id_o,
  output logic [15:0]                   tx_mesh_origin_addr_o,
  output logic [15:0]                   tx_mesh_final_addr_o,
  output logic [`MFRF_HOPS_W-1:0]       tx_hops_left_field_o,
  output logic [1:0]                    tx_addressing_mode_field_o,
  output logic [7:0]                    tx_tag_o,
  output logic                          dlv_valid_o,
  input  wire logic                     dlv_ready_i,
  output logic [15:0]                   dlv_mesh_origin_addr_o,
  output logic [7:0]                    dlv_tag_o
);
  localparam int NE = 1 << IDX_W;
  localparam int HW = `MFRF_HOPS_W;

  if (IDX_W < 1 || IDX_W > 8) begin : g_chk
    $error("IDX_W must lie between 1 and 8");
  end

  typedef struct packed {
    logic [NE-1:0]        member;
    logic [NE-1:0]        bprev;
    logic [NE-1:0][15:0]  nhop;
    logic [NE-1:0]        dvld;
    logic [NE-1:0][7:0]   dseq;
    logic [2:0]           ctrl;
    logic [15:0]          node;
    logic [HW-1:0]        maxh;
    logic [15:0]          bnext;
    logic [15:0]          nfwd;
    logic [15:0]          ndlv;
    logic [15:0]          ndrop;
    logic [1:0]           cnt;
    logic                 tv;
    mfrf_txrec_t          e0;
    mfrf_txrec_t          e1;
    logic                 dv;
    logic [15:0]          d_origin;
    logic [7:0]           d_tag;
    logic                 rdy;
    logic                 grant;
    logic                 rxr;
    logic                 orr;
    logic                 aw_ok;
    logic                 w_ok;
    logic [7:0]           awa;
    logic [31:0]          wd;
    logic [3:0]           ws;
    logic                 awr;
    logic                 wr;
    logic                 bv;
    logic [1:0]           br;
    logic                 arr;
    logic                 rv;
    logic [31:0]          rd;
    logic [1:0]           rr;
  } mfrf_st_t;

  mfrf_st_t s;
  mfrf_st_t next_s;
  logic     rx_take;
  logic     org_take;

  function automatic logic [IDX_W-1:0] idx(input logic [15:0] id);
    return id[IDX_W-1:0];
  endfunction

  // Identifiers beyond the table reach are treated as unknown rather than aliased.
  function automatic logic in_db(input logic [15:0] id);
    return ((id >> IDX_W) == 16'h0000) && s.member[idx(id)];
  endfunction

  function automatic logic in_bdb(input logic [15:0] id);
    return ((id >> IDX_W) == 16'h0000) && s.bprev[idx(id)];
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign rx_take  = rx_valid_i && s.rxr;
  assign org_take = org_valid_i && s.orr;

  always_comb begin
    mfrf_dec_t   dec;
    mfrf_txrec_t rec;
    logic        ok;
    logic        dup;
    logic [31:0] wv;
    logic        hset;
    next_s = s;
    hset = 1'b0;
    dec = MFRF_DEC_DROP;
    rec = '0;
    ok = 1'b0;
    dup = 1'b0;
    wv = 32'h0000_0000;
    if (s.cnt != 2'd0 && tx_ready_i) begin
      next_s.e0  = s.e1;
      next_s.cnt = s.cnt - 2'd1;
    end
    if (s.dv && dlv_ready_i) begin
      next_s.dv = 1'b0;
    end
    rec.origin     = rx_mesh_origin_addr_i;
    rec.final_addr = rx_mesh_final_addr_i;
    rec.hops       = rx_hops_left_field_i - HW'(1); // [R02]
    rec.addressing_mode_field        = `MFRF_ADM_SHORT;
    rec.tag        = rx_tag_i;
    // All table lookups below are taken from the registered tables of this cycle.
    if (rx_take) begin // [R19]
      if (!rx_mesh_hdr_i) begin
        dec        = MFRF_DEC_DLV;
        rec.origin = rx_source_short_id_i;
      end else if (rx_mesh_final_addr_i == s.node) begin
        dec = in_db(rx_source_short_id_i) ? MFRF_DEC_DLV : MFRF_DEC_DROP; // [R06]
      end else if (rx_mesh_final_addr_i == `MFRF_ALL_NODES) begin
        ok  = in_bdb(rx_source_short_id_i) && in_db(rx_mesh_origin_addr_i); // [R15]
        dup = s.dvld[idx(rx_mesh_origin_addr_i)]
              && s.dseq[idx(rx_mesh_origin_addr_i)] == rx_tag_i; // [R12] [R16]
        rec.dest = s.bnext; // [R14] [R11]
        if (!ok || dup) begin
          dec = MFRF_DEC_DROP; // [R13]
        end else if (s.ctrl[`MFRF_CTRL_RELAY] && s.ctrl[`MFRF_CTRL_BCAST]
                     && rx_hops_left_field_i != HW'(0)) begin
          dec = MFRF_DEC_BOTH; // [R12] [R03]
        end else begin
          dec = MFRF_DEC_DLV; // [R16]
        end
      end else begin
        rec.dest = rx_sr_valid_i ? rx_sr_next_i
                                 : s.nhop[idx(rx_mesh_final_addr_i)]; // [R04]
        ok = s.ctrl[`MFRF_CTRL_RELAY] && s.ctrl[`MFRF_CTRL_UNI] // [R17] [R18]
             && (rx_dest_short_id_i == s.node || rx_dest_short_id_i == `MFRF_ALL_NODES)
             && in_db(rx_source_short_id_i) && in_db(rx_mesh_origin_addr_i) // [R01]
             && in_db(rx_mesh_final_addr_i) // [R05]
             && rx_hops_left_field_i != HW'(0); // [R03]
        dec = ok ? MFRF_DEC_FWD : MFRF_DEC_DROP;
      end
    end else if (org_take) begin
      rec.addressing_mode_field        = `MFRF_ADM_SHORT; // [R07]
      rec.hops       = s.maxh; // [R08]
      rec.origin     = s.node; // [R09]
      rec.final_addr = org_mesh_final_addr_i;
      rec.tag        = org_tag_i;
      rec.dest       = (org_mesh_final_addr_i == `MFRF_ALL_NODES) ? s.bnext // [R10]
                       : s.nhop[idx(org_mesh_final_addr_i)];
      dec = s.ctrl[`MFRF_CTRL_RELAY] ? MFRF_DEC_FWD : MFRF_DEC_DROP; // [R18]
    end
    if ((rx_take || org_take) && (dec == MFRF_DEC_FWD || dec == MFRF_DEC_BOTH)) begin
      if (next_s.cnt == 2'd0) begin
        next_s.e0 = rec;
      end else begin
        next_s.e1 = rec;
      end
      next_s.cnt  = next_s.cnt + 2'd1;
      next_s.nfwd = s.nfwd + 16'h0001;
    end
    if (rx_take && (dec == MFRF_DEC_DLV || dec == MFRF_DEC_BOTH)) begin
      next_s.dv       = 1'b1;
      next_s.d_origin = rec.origin;
      next_s.d_tag    = rx_tag_i;
      next_s.ndlv     = s.ndlv + 16'h0001;
      if (rx_mesh_hdr_i && rx_mesh_final_addr_i == `MFRF_ALL_NODES) begin
        hset = 1'b1;
        next_s.dvld[idx(rx_mesh_origin_addr_i)] = 1'b1;
        next_s.dseq[idx(rx_mesh_origin_addr_i)] = rx_tag_i;
      end
    end
    if ((rx_take || org_take) && dec == MFRF_DEC_DROP) begin
      next_s.ndrop = s.ndrop + 16'h0001;
    end
    next_s.tv    = next_s.cnt != 2'd0;
    next_s.grant = !s.grant;
    // Ready looks at the next fill so a take in a ready cycle always finds room.
    next_s.rdy   = next_s.cnt != 2'd2 && !next_s.dv;
    next_s.rxr   = next_s.rdy && next_s.grant;
    next_s.orr   = next_s.rdy && !next_s.grant;

    if (s_axi_awvalid_i && s.awr) begin
      next_s.aw_ok = 1'b1;
      next_s.awa   = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.wr) begin
      next_s.w_ok = 1'b1;
      next_s.wd   = s_axi_wdata_i;
      next_s.ws   = s_axi_wstrb_i;
    end
    if (s.aw_ok && s.w_ok) begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok  = 1'b0;
      next_s.bv    = 1'b1;
      next_s.br    = `MFRF_RESP_OKAY;
      unique case (s.awa)
        `MFRF_OFF_CTRL: begin
          wv = wmerge({29'h0, s.ctrl}, s.wd, s.ws);
          next_s.ctrl = wv[2:0];
        end
        `MFRF_OFF_NODE: begin
          wv = wmerge({16'h0, s.node}, s.wd, s.ws);
          next_s.node = wv[15:0];
        end
        `MFRF_OFF_HOPS: begin
          wv = wmerge({{(32 - HW){1'b0}}, s.maxh}, s.wd, s.ws);
          next_s.maxh = wv[HW-1:0];
        end
        `MFRF_OFF_BNEXT: begin
          wv = wmerge({16'h0, s.bnext}, s.wd, s.ws);
          next_s.bnext = wv[15:0];
        end
        `MFRF_OFF_TBL: begin
          // Only a full-word write commits an entry; it also forgets that origin's history.
          if (s.ws == 4'hF) begin // [R19]
            next_s.member[s.wd[`MFRF_TBL_IDX_LSB +: IDX_W]] = s.wd[`MFRF_TBL_MEMBER];
            next_s.bprev[s.wd[`MFRF_TBL_IDX_LSB +: IDX_W]]  = s.wd[`MFRF_TBL_BPREV];
            next_s.nhop[s.wd[`MFRF_TBL_IDX_LSB +: IDX_W]]   = s.wd[15:0];
            // A frame recorded in the same cycle keeps its history: the set wins.
            if (!(hset && s.wd[`MFRF_TBL_IDX_LSB +: IDX_W] == idx(rx_mesh_origin_addr_i))) begin
              next_s.dvld[s.wd[`MFRF_TBL_IDX_LSB +: IDX_W]] = 1'b0;
            end
          end
        end
        `MFRF_OFF_STAT0, `MFRF_OFF_STAT1: begin
          next_s.br = `MFRF_RESP_OKAY;
        end
        default: begin
          next_s.br = `MFRF_RESP_SLVERR;
        end
      endcase
    end
    if (s.bv && s_axi_bready_i) begin
      next_s.bv = 1'b0;
    end
    next_s.awr = !next_s.aw_ok && !next_s.bv;
    next_s.wr  = !next_s.w_ok && !next_s.bv;

    if (s_axi_arvalid_i && s.arr) begin
      next_s.rv = 1'b1;
      next_s.rr = `MFRF_RESP_OKAY;
      unique case (s_axi_araddr_i)
        `MFRF_OFF_CTRL:  next_s.rd = {29'h0, s.ctrl};
        `MFRF_OFF_NODE:  next_s.rd = {16'h0, s.node};
        `MFRF_OFF_HOPS:  next_s.rd = {{(32 - HW){1'b0}}, s.maxh};
        `MFRF_OFF_BNEXT: next_s.rd = {16'h0, s.bnext};
        `MFRF_OFF_TBL:   next_s.rd = 32'h0000_0000;
        `MFRF_OFF_STAT0: next_s.rd = {s.ndlv, s.nfwd};
        `MFRF_OFF_STAT1: next_s.rd = {16'h0, s.ndrop};
        default: begin
          next_s.rd = 32'h0000_0000;
          next_s.rr = `MFRF_RESP_SLVERR;
        end
      endcase
    end else if (s.rv && s_axi_rready_i) begin
      next_s.rv = 1'b0;
    end
    next_s.arr = !next_s.rv;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s       <= '0;
      s.maxh  <= `MFRF_HOPS_RST;
      s.bnext <= `MFRF_BNEXT_RST;
      s.rdy   <= 1'b1;
      s.orr   <= 1'b1;
      s.awr   <= 1'b1;
      s.wr    <= 1'b1;
      s.arr   <= 1'b1;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign s_axi_awready_o            = s.awr;
  assign s_axi_wready_o             = s.wr;
  assign s_axi_bvalid_o             = s.bv;
  assign s_axi_bresp_o              = s.br;
  assign s_axi_arready_o            = s.arr;
  assign s_axi_rvalid_o             = s.rv;
  assign s_axi_rdata_o              = s.rd;
  assign s_axi_rresp_o              = s.rr;
  assign rx_ready_o                 = s.rxr;
  assign org_ready_o                = s.orr;
  assign tx_valid_o                 = s.tv;
  assign tx_dest_short_id_o         = s.e0.dest;
  assign tx_mesh_origin_addr_o      = s.e0.origin;
  assign tx_mesh_final_addr_o       = s.e0.final_addr;
  assign tx_hops_left_field_o       = s.e0.hops;
  assign tx_addressing_mode_field_o = s.e0.addressing_mode_field;
  assign tx_tag_o                   = s.e0.tag;
  assign dlv_valid_o                = s.dv;
  assign dlv_mesh_origin_addr_o     = s.d_origin;
  assign dlv_tag_o                  = s.d_tag;

  a_hops_decrement: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R02]
    ce_i && rx_take && rx_mesh_hdr_i && s.cnt == 2'd0 && rx_mesh_final_addr_i != s.node
    |=> tx_valid_o |-> tx_hops_left_field_o == $past(rx_hops_left_field_i) - HW'(1))
    else $error("relayed hop count is not the received count minus one");

  a_zero_hops_drop: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R03]
    ce_i && rx_take && rx_mesh_hdr_i && rx_hops_left_field_i == HW'(0)
    && rx_mesh_final_addr_i != s.node && rx_mesh_final_addr_i != `MFRF_ALL_NODES
    |=> s.ndrop == $past(s.ndrop) + 16'h0001 && s.nfwd == $past(s.nfwd))
    else $error("frame with zero hops left was not dropped");

  a_final_unknown: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R05]
    ce_i && rx_take && rx_mesh_hdr_i && !in_db(rx_mesh_final_addr_i)
    && rx_mesh_final_addr_i != s.node && rx_mesh_final_addr_i != `MFRF_ALL_NODES
    |=> s.nfwd == $past(s.nfwd))
    else $error("frame to unknown final address was relayed");

  a_dest_src_chk: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R06]
    ce_i && rx_take && rx_mesh_hdr_i && rx_mesh_final_addr_i == s.node
    |=> dlv_valid_o == $past(in_db(rx_source_short_id_i)))
    else $error("delivery to this node disagrees with the previous hop check");

  a_bcast_origin: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R09]
    ce_i && org_take && s.ctrl[`MFRF_CTRL_RELAY] && s.cnt == 2'd0
    && org_mesh_final_addr_i == `MFRF_ALL_NODES
    |=> tx_valid_o && tx_mesh_origin_addr_o == $past(s.node)
    && tx_mesh_final_addr_o == `MFRF_ALL_NODES && tx_dest_short_id_o == $past(s.bnext))
    else $error("originated broadcast carries wrong addresses");

  a_orig_fields: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R07] [R08]
    ce_i && org_take && s.ctrl[`MFRF_CTRL_RELAY] && s.cnt == 2'd0
    |=> tx_addressing_mode_field_o == `MFRF_ADM_SHORT && tx_hops_left_field_o == $past(s.maxh))
    else $error("originated frame has wrong mode flags or hop count");

  a_bcast_once: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R16]
    ce_i && rx_take && rx_mesh_hdr_i && rx_mesh_final_addr_i == `MFRF_ALL_NODES
    && s.dvld[idx(rx_mesh_origin_addr_i)] && s.dseq[idx(rx_mesh_origin_addr_i)] == rx_tag_i
    |=> !dlv_valid_o && s.nfwd == $past(s.nfwd))
    else $error("repeated broadcast copy was delivered or relayed");

  a_not_assigned: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R17]
    ce_i && rx_take && rx_mesh_hdr_i && !s.ctrl[`MFRF_CTRL_UNI]
    && rx_mesh_final_addr_i != s.node && rx_mesh_final_addr_i != `MFRF_ALL_NODES
    |=> s.ndrop == $past(s.ndrop) + 16'h0001)
    else $error("unassigned node kept a frame for another node");

  a_relay_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R18]
    ce_i && org_take && !s.ctrl[`MFRF_CTRL_RELAY] && s.cnt == 2'd0
    |=> !tx_valid_o [*2])
    else $error("frame originated for relaying while relaying is off");

  a_bcast_reject: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R13]
    ce_i && rx_take && rx_mesh_hdr_i && rx_mesh_final_addr_i == `MFRF_ALL_NODES
    && !in_bdb(rx_source_short_id_i)
    |=> s.nfwd == $past(s.nfwd) && !dlv_valid_o)
    else $error("broadcast from unknown previous hop was accepted");
endmodule // mfrf_relay

// file: testbench/mfrf_peer.sv
// Far-side model: neighbour link sink and upper application entity, both with stalls.
module mfrf_peer
  import mfrf_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hold_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  input  wire mfrf_txrec_t tx_rec_i,
  input  wire logic        dlv_valid_i,
  output logic             dlv_ready_o,
  input  wire logic [15:0] dlv_origin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  mfrf_txrec_t rec [0:15];
  int          tx_cnt;
  int          dlv_cnt;
  logic [15:0] dlv_last;
  logic        tick;
  // Ready only on every other cycle, so records must survive a slow neighbour.
  assign tx_ready_o  = tick & !hold_i;
  assign dlv_ready_o = !tick;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick <= 1'b0;
    end else begin
      tick <= !tick;
      if (tx_valid_i && tx_ready_o) begin
        rec[tx_cnt] <= tx_rec_i;
        tx_cnt      <= tx_cnt + 1;
      end
      if (dlv_valid_i && dlv_ready_o) begin
        dlv_last <= dlv_origin_i;
        dlv_cnt  <= dlv_cnt + 1;
      end
    end
  end
endmodule // mfrf_peer

// file: testbench/tb.sv
// Self-checking bench of the mesh relay filter.
`include "mfrf_cfg.svh"
module tb
  import mfrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rn, awv, wv, bry, arv, rry, rxv, mh, srv, orv, hold, f;
  logic [7:0]  aw, ar, rtag, otag;
  logic [31:0] wd;
  logic [15:0] sp, sd, so, sf, srn, ofin;
  logic [3:0]  hp;
  wire         awr, wr, bv, arr, rv, rxr, orr, txv, txr, dv, dr;
  wire [1:0]   br, rr;
  wire [31:0]  rd;
  wire [15:0]  dorg;
  wire [7:0]   dtag;
  wire mfrf_txrec_t t;
  int err_count, comparisons, nt, nd, cyc;
  mfrf_relay #(.IDX_W(6)) i_mfrf_relay (
    .core_clk_i(clk), .rst_n_i(rn), .ce_i(1'b1), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .rx_valid_i(rxv),
    .rx_ready_o(rxr), .rx_mesh_hdr_i(mh), .rx_source_short_id_i(sp), .rx_dest_short_id_i(sd),
    .rx_mesh_origin_addr_i(so), .rx_mesh_final_addr_i(sf), .rx_hops_left_field_i(hp),
    .rx_sr_valid_i(srv), .rx_sr_next_i(srn), .rx_tag_i(rtag), .org_valid_i(orv),
    .org_ready_o(orr), .org_mesh_final_addr_i(ofin), .org_tag_i(otag), .tx_valid_o(txv),
    .tx_ready_i(txr), .tx_dest_short_id_o(t.dest), .tx_mesh_origin_addr_o(t.origin),
    .tx_mesh_final_addr_o(t.final_addr), .tx_hops_left_field_o(t.hops),
    .tx_addressing_mode_field_o(t.addressing_mode_field), .tx_tag_o(t.tag), .dlv_valid_o(dv),
    .dlv_ready_i(dr), .dlv_mesh_origin_addr_o(dorg), .dlv_tag_o(dtag));
  mfrf_peer i_mfrf_peer (.core_clk_i(clk), .rst_n_i(rn), .hold_i(hold), .tx_valid_i(txv),
    .tx_ready_o(txr), .tx_rec_i(t), .dlv_valid_i(dv), .dlv_ready_o(dr), .dlv_origin_i(dorg));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {aw, wd, awv, wv, bry} <= {a, d, 3'b111};
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    bry <= 1'b0;
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {ar, arv, rry} <= {a, 2'b11};
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rd;
    r = rr;
    rry <= 1'b0;
  endtask
  task automatic rx(input logic [15:0] p, d, o, fi, input logic [3:0] h, input logic [7:0] g);
    @(posedge clk);
    {sp, sd, so, sf, hp, rtag, rxv} <= {p, d, o, fi, h, g, 1'b1};
    do @(posedge clk); while (!rxr);
    rxv <= 1'b0;
  endtask
  task automatic org(input logic [15:0] fi, input logic [7:0] g);
    @(posedge clk);
    {ofin, otag, orv} <= {fi, g, 1'b1};
    do @(posedge clk); while (!orr);
    orv <= 1'b0;
  endtask
  // A fixed window is long enough for a relayed record even with the slow neighbour.
  task automatic look(input string n, input int et, input int ed);
    repeat (12) @(posedge clk);
    nt += et;
    nd += ed;
    chk({n, " tx"}, i_mfrf_peer.tx_cnt, nt);
    chk({n, " dlv"}, i_mfrf_peer.dlv_cnt, nd);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd32(`MFRF_OFF_HOPS, d, r);
    chk("hops reset", d, 32'h7);
    rd32(`MFRF_OFF_BNEXT, d, r);
    chk("bnext reset", d, 32'hFFFF);
    rd32(8'h40, d, r);
    chk("unmapped resp", r, `MFRF_RESP_SLVERR);
    wr32(`MFRF_OFF_NODE, 32'h5);
    wr32(`MFRF_OFF_BNEXT, 32'h33);
    wr32(`MFRF_OFF_TBL, 32'h0301_0000);
    wr32(`MFRF_OFF_TBL, 32'h0102_0000);
    wr32(`MFRF_OFF_TBL, 32'h0103_0022);
    wr32(`MFRF_OFF_TBL, 32'h0104_0000);
    wr32(`MFRF_OFF_CTRL, 32'h7);
    rd32(`MFRF_OFF_NODE, d, r);
    chk("node", d, 32'h5);
    $display("done registers");
  endtask
  task automatic t_uni;
    rx(16'h1, 16'h5, 16'h2, 16'h3, 4'h4, 8'h10);
    look("uni relay", 1, 0);
    chk("uni rec", i_mfrf_peer.rec[nt-1], {16'h22, 16'h2, 16'h3, 4'h3, 2'h3, 8'h10});
    {srv, srn} <= {1'b1, 16'h44};
    rx(16'h1, 16'hFFFF, 16'h2, 16'h3, 4'h1, 8'h11);
    look("uni route", 1, 0);
    chk("route rec", i_mfrf_peer.rec[nt-1], {16'h44, 16'h2, 16'h3, 4'h0, 2'h3, 8'h11});
    srv <= 1'b0;
    rx(16'h1, 16'h5, 16'h2, 16'h3, 4'h0, 8'h12);
    look("hops zero", 0, 0);
    rx(16'h1, 16'h5, 16'h2, 16'h9, 4'h4, 8'h13);
    look("unknown final", 0, 0);
    rx(16'h1, 16'h5, 16'h7, 16'h3, 4'h4, 8'h14);
    look("unknown origin", 0, 0);
    rx(16'h7, 16'h5, 16'h2, 16'h5, 4'h3, 8'h20);
    look("own bad prev", 0, 0);
    rx(16'h2, 16'h5, 16'h3, 16'h5, 4'h3, 8'h21);
    look("own frame", 0, 1);
    chk("own origin", i_mfrf_peer.dlv_last, 16'h3);
    chk("own tag", dtag, 8'h21);
    $display("done unicast");
  endtask
  task automatic t_bc;
    rx(16'h1, 16'hFFFF, 16'h2, 16'hFFFF, 4'h5, 8'h30);
    look("bc relay", 1, 1);
    chk("bc rec", i_mfrf_peer.rec[nt-1], {16'h33, 16'h2, 16'hFFFF, 4'h4, 2'h3, 8'h30});
    rx(16'h1, 16'hFFFF, 16'h2, 16'hFFFF, 4'h5, 8'h30);
    look("bc repeat", 0, 0);
    rx(16'h4, 16'hFFFF, 16'h2, 16'hFFFF, 4'h5, 8'h31);
    look("bc bad prev", 0, 0);
    rx(16'h1, 16'hFFFF, 16'h7, 16'hFFFF, 4'h5, 8'h32);
    look("bc bad origin", 0, 0);
    rx(16'h1, 16'hFFFF, 16'h2, 16'hFFFF, 4'h0, 8'h33);
    look("bc hops zero", 0, 1);
    $display("done broadcast");
  endtask
  task automatic t_org;
    hold <= 1'b1;
    org(16'hFFFF, 8'h50);
    org(16'h3, 8'h51);
    f = 1'b0;
    repeat (4) begin
      @(posedge clk);
      f |= orr;
    end
    chk("full refuses", f, 1'b0);
    hold <= 1'b0;
    look("originate", 2, 0);
    chk("org bc", i_mfrf_peer.rec[nt-2], {16'h33, 16'h5, 16'hFFFF, 4'h7, 2'h3, 8'h50});
    chk("org uni", i_mfrf_peer.rec[nt-1], {16'h22, 16'h5, 16'h3, 4'h7, 2'h3, 8'h51});
    $display("done originate");
  endtask
  task automatic t_plain;
    wr32(`MFRF_OFF_CTRL, 32'h1);
    rx(16'h1, 16'hFFFF, 16'h2, 16'hFFFF, 4'h5, 8'h40);
    look("leaf bc", 0, 1);
    rx(16'h1, 16'hFFFF, 16'h2, 16'hFFFF, 4'h5, 8'h40);
    look("leaf repeat", 0, 0);
    rx(16'h1, 16'h5, 16'h2, 16'h3, 4'h4, 8'h41);
    look("unassigned", 0, 0);
    wr32(`MFRF_OFF_CTRL, 32'h0);
    org(16'hFFFF, 8'h42);
    look("off org", 0, 0);
    rx(16'h1, 16'h5, 16'h2, 16'h3, 4'h4, 8'h43);
    look("off relay", 0, 0);
    mh <= 1'b0;
    rx(16'h9, 16'h5, 16'h2, 16'h3, 4'h4, 8'h44);
    look("plain frame", 0, 1);
    chk("plain origin", i_mfrf_peer.dlv_last, 16'h9);
    mh <= 1'b1;
    $display("done relay off");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    {rn, awv, wv, bry, arv, rry, rxv, srv, orv, hold, f} = '0;
    {aw, wd, ar, sp, sd, so, sf, hp, srn, rtag, ofin, otag} = '0;
    mh = 1'b1;
    repeat (5) @(posedge clk);
    rn <= 1'b1;
    t_regs();
    t_uni();
    t_bc();
    t_org();
    t_plain();
    finish_test();
  end
endmodule // tb
